// ### hdl/vrrl_core.sv
/*
  Voltage relay record logic: indicator latching, push-button functions,
  board routing, records 0..8, bus traffic monitor, password gate, display.
  Assumes stage signals, measured voltage and percentages come from the
  measuring stages on clock_i; buttons and remote reset come from pins.
*/
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "vrrl_defines.svh"
module vrrl_core
  import vrrl_pkg::*;
(
  input wire logic clock_i, // 250 MHz clock
  input wire logic sys_rst_i, // Async reset, also supply loss
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic remote_i, // Write comes from serial link
  input wire vrrl_stage_t stage_i, // Stage start/operate levels
  input wire logic [9:0] voltage_i, // Measured voltage, per unit scaled
  input wire logic [6:0] ov_pct_i, // Overvoltage elapsed percentage
  input wire logic [6:0] uv_pct_i, // Undervoltage elapsed percentage
  input wire logic [9:0] volt_ab_i, // Phase pair ab voltage
  input wire logic [9:0] volt_bc_i, // Phase pair bc voltage
  input wire logic [9:0] volt_ca_i, // Phase pair ca voltage
  input wire logic [2:0] block_i, // Blocking sources into undervoltage
  input wire logic step_btn_i, // Step push-button pin
  input wire logic reset_btn_i, // Reset push-button pin
  input wire logic remote_reset_i, // Remote reset pin
  output vrrl_stage_t led_o, // Indicator outputs
  output logic [2:0] start_route_o, // Routed outgoing starts
  output logic uv_blocked_o, // Undervoltage trip blocked
  output vrrl_digits_t digits_o, // Display digits
  output logic [2:0] pair_led_o // Phase pair indicator
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {remote_reset_i, reset_btn_i, step_btn_i};
      sync2_r <= sync1_r;
    end
  end

  logic step_s;
  logic reset_s;
  logic remote_rst_s;
  assign step_s = sync2_r[0];
  assign reset_s = sync2_r[1];
  assign remote_rst_s = sync2_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] vrrl_digit(input logic [9:0] v, input logic [1:0] pos);
    logic [9:0] q;
    q = v;
    for (int i = 0; i < 3; i++) begin
      if (int'(pos) == i) begin
        return 4'(q % 10'd10);
      end
      q = q / 10'd10;
    end
    return `VRRL_DIGIT_ZERO;
  endfunction

  function automatic vrrl_digits_t vrrl_value(input logic [3:0] lead, input logic [9:0] v);
    vrrl_digits_t d;
    d.digit_left = lead;
    d.digit_mid_l = vrrl_digit(v, 2'd2);
    d.digit_mid_r = vrrl_digit(v, 2'd1);
    d.digit_right = vrrl_digit(v, 2'd0);
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  vrrl_state_t st_r;
  vrrl_state_t st_nxt;

  logic both_btn;
  logic step_rise;
  logic manual_clear;
  logic erase;
  logic wr_ok;
  logic ov_start_rise;
  logic uv_start_rise;
  logic [9:0] pair_volt;

  always_comb begin
    st_nxt = st_r;
    both_btn = step_s && reset_s;
    step_rise = st_r.btn_step_d == 2'b01;
    // Clearing needs bit zero only; upper selector bits ignored
    manual_clear = reset_s || remote_rst_s ||
                   (st_r.button_sel[`VRRL_BIT_BUTTON_FN] && step_s);
    ov_start_rise = stage_i.ov_start && !st_r.stage_d.ov_start;
    uv_start_rise = stage_i.uv_start && !st_r.stage_d.uv_start;
    erase = both_btn || st_r.clear_pend;
    wr_ok = wr_i && (!remote_i || st_r.unlocked);

    st_nxt.stage_d = stage_i;
    st_nxt.btn_step_d = {st_r.btn_step_d[0], step_s};
    st_nxt.clear_pend = 1'b0;

    // Register writes
    if (wr_ok) begin
      case (addr_i)
        `VRRL_ADDR_LATCH_SEL: st_nxt.latch_sel = wdata_i[3:0];
        `VRRL_ADDR_BUTTON_SEL: st_nxt.button_sel = wdata_i;
        `VRRL_ADDR_ROUTING: st_nxt.routing = wdata_i;
        `VRRL_ADDR_PASSWORD: st_nxt.password = wdata_i;
        `VRRL_ADDR_CONTROL: begin
          st_nxt.clear_pend = wdata_i[`VRRL_CTRL_CLEAR];
          st_nxt.link_ok = wdata_i[`VRRL_CTRL_LINK_OK];
          if (wdata_i[`VRRL_CTRL_LOCK]) begin
            st_nxt.unlocked = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Password key accepted from the link even while locked
    if (wr_i && remote_i && addr_i == `VRRL_ADDR_REMOTE_KEY) begin
      st_nxt.unlocked = wdata_i == st_r.password;
    end

    // Indicators, generated per bit
    for (int i = 0; i < 4; i++) begin
      if (!st_r.latch_sel[i]) begin
        st_nxt.led[i] = stage_i[3 - i];
      end else if (stage_i[3 - i]) begin
        st_nxt.led[i] = 1'b1;
      end else if (manual_clear) begin
        st_nxt.led[i] = 1'b0;
      end
    end

    // Record 1: start-sequence maximum
    if (ov_start_rise) begin
      st_nxt.rec1_max = voltage_i;
      st_nxt.rec1_valid = 1'b1;
      st_nxt.rec1_frozen = 1'b0;
    end else if (stage_i.ov_op) begin
      st_nxt.rec1_frozen = 1'b1;
    end else if (stage_i.ov_start && !st_r.rec1_frozen && voltage_i > st_r.rec1_max) begin
      st_nxt.rec1_max = voltage_i;
    end
    // Record 3: start-sequence minimum
    if (uv_start_rise) begin
      st_nxt.rec3_min = voltage_i;
      st_nxt.rec3_valid = 1'b1;
      st_nxt.rec3_frozen = 1'b0;
    end else if (stage_i.uv_op) begin
      st_nxt.rec3_frozen = 1'b1;
    end else if (stage_i.uv_start && !st_r.rec3_frozen && voltage_i < st_r.rec3_min) begin
      st_nxt.rec3_min = voltage_i;
    end
    if (voltage_i > st_r.rec2_max) begin
      st_nxt.rec2_max = voltage_i;
    end
    if (voltage_i < st_r.rec4_min) begin
      st_nxt.rec4_min = voltage_i;
    end
    // 8-bit counters wrap naturally past 255
    if (ov_start_rise) begin
      st_nxt.rec5_count = st_r.rec5_count + 8'h01;
    end
    if (uv_start_rise) begin
      st_nxt.rec6_count = st_r.rec6_count + 8'h01;
    end
    // Percentages: restart at start, pinned at full after trip
    if (ov_start_rise) begin
      st_nxt.rec7_pct = `VRRL_PCT_ZERO;
    end else if (stage_i.ov_op) begin
      st_nxt.rec7_pct = `VRRL_PCT_FULL;
    end else if (stage_i.ov_start) begin
      st_nxt.rec7_pct = ov_pct_i;
    end
    if (uv_start_rise) begin
      st_nxt.rec8_pct = `VRRL_PCT_ZERO;
    end else if (stage_i.uv_op) begin
      st_nxt.rec8_pct = `VRRL_PCT_FULL;
    end else if (stage_i.uv_start) begin
      st_nxt.rec8_pct = uv_pct_i;
    end

    // Erase of records 1..8
    if (erase) begin
      st_nxt.rec1_max = `VRRL_VOLT_ZERO;
      st_nxt.rec1_valid = 1'b0;
      st_nxt.rec1_frozen = 1'b0;
      st_nxt.rec2_max = `VRRL_VOLT_ZERO;
      st_nxt.rec3_min = `VRRL_VOLT_MAX;
      st_nxt.rec3_valid = 1'b0;
      st_nxt.rec3_frozen = 1'b0;
      st_nxt.rec4_min = `VRRL_VOLT_MAX;
      st_nxt.rec5_count = `VRRL_COUNT_ZERO;
      st_nxt.rec6_count = `VRRL_COUNT_ZERO;
      st_nxt.rec7_pct = `VRRL_PCT_ZERO;
      st_nxt.rec8_pct = `VRRL_PCT_ZERO;
    end

    // Bus traffic monitor; divider slows the roll to a readable rate
    if (st_r.link_ok) begin
      st_nxt.roll = `VRRL_COUNT_ZERO;
      st_nxt.roll_div = 16'h0000;
    end else if (st_r.roll_div == `VRRL_ROLL_DIV) begin
      st_nxt.roll_div = 16'h0000;
      st_nxt.roll = st_r.roll + 8'h01;
    end else begin
      st_nxt.roll_div = st_r.roll_div + 16'h0001;
    end

    // Display paging on step press, unless both buttons held
    if (step_rise && !reset_s) begin
      if (st_r.page == 4'h8) begin
        st_nxt.page = 4'h0;
        case (st_r.pair)
          VRRL_PAIR_AB: st_nxt.pair = VRRL_PAIR_BC;
          VRRL_PAIR_BC: st_nxt.pair = VRRL_PAIR_CA;
          default: st_nxt.pair = VRRL_PAIR_AB;
        endcase
      end else begin
        st_nxt.page = st_r.page + 4'h1;
      end
    end

    case (st_r.pair)
      VRRL_PAIR_BC: pair_volt = volt_bc_i;
      VRRL_PAIR_CA: pair_volt = volt_ca_i;
      default: pair_volt = volt_ab_i;
    endcase

    case (st_r.page)
      4'h0: begin
        st_nxt.digits.digit_left = remote_rst_s ? `VRRL_DIGIT_ONE : `VRRL_DIGIT_ZERO;
        st_nxt.digits.digit_mid_l = `VRRL_DIGIT_ZERO;
        st_nxt.digits.digit_mid_r = `VRRL_DIGIT_ZERO;
        st_nxt.digits.digit_right = uv_blocked_o ? `VRRL_DIGIT_TWO : `VRRL_DIGIT_ZERO;
      end
      4'h1: st_nxt.digits = vrrl_value(4'h1, st_r.rec1_valid ? st_r.rec1_max : `VRRL_VOLT_ZERO);
      4'h2: st_nxt.digits = vrrl_value(4'h2, st_r.rec2_max);
      4'h3: begin
        if (st_r.rec3_valid) begin
          st_nxt.digits = vrrl_value(4'h3, st_r.rec3_min);
        end else begin
          st_nxt.digits = {4'h3, `VRRL_DIGIT_DASH, `VRRL_DIGIT_DASH, `VRRL_DIGIT_DASH};
        end
      end
      4'h4: st_nxt.digits = vrrl_value(4'h4, st_r.rec4_min);
      4'h5: st_nxt.digits = vrrl_value(4'h5, {2'b00, st_r.rec5_count});
      4'h6: st_nxt.digits = vrrl_value(4'h6, {2'b00, st_r.rec6_count});
      4'h7: st_nxt.digits = vrrl_value(4'h7, {3'b000, st_r.rec7_pct});
      default: st_nxt.digits = vrrl_value(4'h8, {3'b000, st_r.rec8_pct});
    endcase
    // Page 0 of measuring view shows the chosen phase pair voltage
    if (st_r.page == 4'h0 && !st_r.btn_step_d[1] && !remote_rst_s && !uv_blocked_o) begin
      st_nxt.digits = vrrl_value(`VRRL_DIGIT_ZERO, pair_volt);
    end

    // Read data
    case (addr_i)
      `VRRL_ADDR_LATCH_SEL: st_nxt.rdata = {4'h0, st_r.latch_sel};
      `VRRL_ADDR_BUTTON_SEL: st_nxt.rdata = st_r.button_sel;
      `VRRL_ADDR_ROUTING: st_nxt.rdata = st_r.routing;
      `VRRL_ADDR_CONTROL: st_nxt.rdata = {5'h00, !st_r.unlocked, st_r.link_ok, 1'b0};
      `VRRL_ADDR_STATUS: st_nxt.rdata = {4'h0, st_r.led};
      `VRRL_ADDR_REC0: st_nxt.rdata = {3'h0, remote_rst_s, 2'h0, uv_blocked_o, 1'b0};
      4'h8: st_nxt.rdata = st_r.rec1_max[9:2];
      4'h9: st_nxt.rdata = st_r.rec2_max[9:2];
      4'hA: st_nxt.rdata = st_r.rec3_min[9:2];
      4'hB: st_nxt.rdata = st_r.rec4_min[9:2];
      4'hC: st_nxt.rdata = st_r.rec5_count;
      4'hD: st_nxt.rdata = st_r.rec6_count;
      4'hE: st_nxt.rdata = {1'b0, st_r.rec7_pct};
      `VRRL_ADDR_REC8: st_nxt.rdata = {1'b0, st_r.rec8_pct};
      default: st_nxt.rdata = st_r.roll; // Password reads back as monitor
    endcase
    if (!rd_i) begin
      st_nxt.rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing; switches 3 and 5 left unused

  assign start_route_o = {st_r.routing[2] & stage_i.uv_start,
                          st_r.routing[1] & stage_i.ov_start,
                          st_r.routing[0] & (stage_i.ov_start | stage_i.uv_start)};
  assign uv_blocked_o = |({st_r.routing[7], st_r.routing[6], st_r.routing[4]} & block_i);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.latch_sel <= `VRRL_LATCH_RESET;
      st_r.button_sel <= `VRRL_BUTTON_RESET;
      st_r.routing <= `VRRL_ROUTING_RESET;
      st_r.password <= `VRRL_PASSWORD_RESET;
      st_r.rec3_min <= `VRRL_VOLT_MAX;
      st_r.rec4_min <= `VRRL_VOLT_MAX;
      st_r.pair <= VRRL_PAIR_AB;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign led_o = st_r.led;
  assign digits_o = st_r.digits;
  assign pair_led_o = {st_r.pair == VRRL_PAIR_CA, st_r.pair == VRRL_PAIR_BC, st_r.pair == VRRL_PAIR_AB};

endmodule

// ### hdl/vrrl_defines.svh
/*
  Constants of the voltage relay record logic: offsets, field positions,
  reset values and counts. Assumes inclusion by the package and the module.
*/
`ifndef VRRL_DEFINES_SVH
`define VRRL_DEFINES_SVH

`define VRRL_ADDR_LATCH_SEL 4'h0
`define VRRL_ADDR_BUTTON_SEL 4'h1
`define VRRL_ADDR_ROUTING 4'h2
`define VRRL_ADDR_PASSWORD 4'h3
`define VRRL_ADDR_REMOTE_KEY 4'h4
`define VRRL_ADDR_CONTROL 4'h5
`define VRRL_ADDR_STATUS 4'h6
`define VRRL_ADDR_REC0 4'h7
`define VRRL_ADDR_REC1 4'h8
`define VRRL_ADDR_REC8 4'hF

`define VRRL_LATCH_RESET 4'hA
`define VRRL_BUTTON_RESET 8'h00
`define VRRL_ROUTING_RESET 8'h00
`define VRRL_PASSWORD_RESET 8'h00

`define VRRL_BIT_OV_START 0
`define VRRL_BIT_OV_OP 1
`define VRRL_BIT_UV_START 2
`define VRRL_BIT_UV_OP 3
`define VRRL_BIT_BUTTON_FN 0

`define VRRL_CTRL_CLEAR 0
`define VRRL_CTRL_LINK_OK 1
`define VRRL_CTRL_LOCK 2

`define VRRL_VOLT_ZERO 10'h000
`define VRRL_VOLT_MAX 10'h3FF
`define VRRL_PCT_FULL 7'h64
`define VRRL_PCT_ZERO 7'h00
`define VRRL_COUNT_ZERO 8'h00
`define VRRL_ROLL_DIV 16'hF423
`define VRRL_DIGIT_ZERO 4'h0
`define VRRL_DIGIT_ONE 4'h1
`define VRRL_DIGIT_TWO 4'h2
`define VRRL_DIGIT_DASH 4'hF

`endif

// ### hdl/vrrl_pkg.sv
/*
  Types of the voltage relay record logic.
  Assumes the defines header is found on the include path.
*/
package vrrl_pkg;
  `include "vrrl_defines.svh"

  typedef enum logic [1:0] {
    VRRL_PAIR_AB,
    VRRL_PAIR_BC,
    VRRL_PAIR_CA
  } vrrl_pair_t;

  typedef struct packed {
    logic ov_start;
    logic ov_op;
    logic uv_start;
    logic uv_op;
  } vrrl_stage_t;

  typedef struct packed {
    logic [3:0] digit_left;
    logic [3:0] digit_mid_l;
    logic [3:0] digit_mid_r;
    logic [3:0] digit_right;
  } vrrl_digits_t;

  typedef struct packed {
    logic [3:0] latch_sel;
    logic [7:0] button_sel;
    logic [7:0] routing;
    logic [7:0] password;
    logic unlocked;
    logic clear_pend;
    logic link_ok;
    logic [9:0] rec1_max;
    logic rec1_valid;
    logic rec1_frozen;
    logic [9:0] rec2_max;
    logic [9:0] rec3_min;
    logic rec3_valid;
    logic rec3_frozen;
    logic [9:0] rec4_min;
    logic [7:0] rec5_count;
    logic [7:0] rec6_count;
    logic [6:0] rec7_pct;
    logic [6:0] rec8_pct;
    vrrl_stage_t stage_d;
    vrrl_stage_t led;
    logic [7:0] roll;
    logic [15:0] roll_div;
    logic [1:0] btn_step_d;
    logic [7:0] rdata;
    logic [3:0] page;
    vrrl_pair_t pair;
    vrrl_digits_t digits;
  } vrrl_state_t;
endpackage

// ### verification/vrrl_checker.sv
/*
  Port checker of the voltage relay record logic.
  Assumes it is bound to vrrl_core, one clock domain.
*/
`timescale 1ns/1ps
module vrrl_checker
  import vrrl_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic [3:0] addr_i, // Address
  input wire logic rd_i, // Read strobe
  input wire logic [7:0] rdata_o, // Read data
  input wire vrrl_stage_t stage_i, // Stage levels
  input wire logic [2:0] block_i, // Blocking sources
  input wire logic remote_reset_i, // Remote reset pin
  input wire vrrl_stage_t led_o, // Indicators
  input wire logic [2:0] start_route_o, // Routed starts
  input wire logic uv_blocked_o, // Undervoltage blocked
  input wire logic [2:0] pair_led_o // Phase pair marker
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] stg_rev;
  // Indicator bit order is the stage bit order reversed
  assign stg_rev = {stage_i[0], stage_i[1], stage_i[2], stage_i[3]};
  ////////////////////////////////////////
  chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  chk_led_follow: assert property (stg_rev != 4'h0 |=> (led_o & $past(stg_rev)) == $past(stg_rev))
    else $error("indicator missed its stage");
  chk_led_cause: assert property ((led_o & ~$past(led_o) & ~$past(stg_rev)) == 4'h0)
    else $error("indicator set without stage");
  chk_route_idle: assert property (!stage_i.ov_start && !stage_i.uv_start |-> start_route_o == 3'b000)
    else $error("start routed without start");
  chk_route_src: assert property ((start_route_o[1] -> stage_i.ov_start) && (start_route_o[2] -> stage_i.uv_start))
    else $error("start routed from wrong stage");
  chk_block_src: assert property (block_i == 3'b000 |-> !uv_blocked_o)
    else $error("blocked without source");
  chk_rec0_zero: assert property (rd_i && addr_i == 4'h7 |=> (rdata_o & 8'hED) == 8'h00)
    else $error("record zero spare digits not zero");
  chk_rec0_block: assert property (rd_i && addr_i == 4'h7 |=> rdata_o[1] == $past(uv_blocked_o))
    else $error("record zero block digit wrong");
  chk_rec0_remote: assert property (remote_reset_i [*4] ##0 (rd_i && addr_i == 4'h7) |=> rdata_o[4])
    else $error("record zero remote digit wrong");
  chk_pct_range: assert property (rd_i && addr_i == 4'hE |=> rdata_o <= 8'h64)
    else $error("percentage above full");
  chk_pair_mark: assert property ($onehot(pair_led_o))
    else $error("pair marker not exactly one");
  cover property (stage_i.ov_start ##1 stage_i.ov_op);
  cover property (rd_i && addr_i == 4'h7);
  cover property (uv_blocked_o);
endmodule

bind vrrl_core vrrl_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .stage_i(stage_i), .block_i(block_i), .remote_reset_i(remote_reset_i), .led_o(led_o),
  .start_route_o(start_route_o), .uv_blocked_o(uv_blocked_o), .pair_led_o(pair_led_o));

// ### verification/vrrl_panel_model.sv
/*
  Front panel model: holds each requested key press for a few cycles.
  Assumes the bench pulses press_i for one cycle.
*/
`timescale 1ns/1ps
module vrrl_panel_model #(
  parameter int HOLD = 6
) (
  input wire logic clock_i, // Clock
  input wire logic [1:0] press_i, // Bit0 step, bit1 reset
  output logic step_btn_o, // Step key pin
  output logic reset_btn_o // Reset key pin
);
  logic [3:0] hold_r = 4'h0;
  logic [1:0] keys_r = 2'b00;
  // Both keys share one hold so a pair reads as simultaneous
  always_ff @(posedge clock_i) begin
    if (press_i != 2'b00) begin
      keys_r <= press_i;
      hold_r <= 4'(HOLD);
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
  assign step_btn_o = (hold_r != 4'h0) && keys_r[0];
  assign reset_btn_o = (hold_r != 4'h0) && keys_r[1];
endmodule

// ### verification/tb_top.sv
/*
  Self-checking bench of the voltage relay record logic.
  Assumes the panel model drives the key pins.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
  import vrrl_pkg::*;
  typedef struct packed {
    logic [7:0] routing;
    vrrl_stage_t stg;
    logic [2:0] blk;
    logic [2:0] route;
    logic blocked;
  } vrrl_row_t;
  localparam vrrl_row_t ROWS [7] = '{'{8'h07, 4'b1000, 3'b000, 3'b011, 1'b0}, '{8'h07, 4'b0010, 3'b000, 3'b101, 1'b0},
    '{8'h28, 4'b1010, 3'b000, 3'b000, 1'b0}, '{8'h10, 4'b0000, 3'b001, 3'b000, 1'b1},
    '{8'h40, 4'b0000, 3'b010, 3'b000, 1'b1}, '{8'h80, 4'b0000, 3'b100, 3'b000, 1'b1},
    '{8'h6F, 4'b0000, 3'b101, 3'b000, 1'b0}};
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic remote = 1'b0;
  vrrl_stage_t stage = 4'h0;
  logic [9:0] volt = 10'h3FF;
  logic [6:0] ov_pct = 7'h00;
  logic [6:0] uv_pct = 7'h00;
  logic [2:0] block = 3'b000;
  logic [1:0] press = 2'b00;
  logic rr = 1'b0;
  logic step_btn;
  logic reset_btn;
  logic [7:0] rdata;
  vrrl_stage_t led;
  logic [2:0] route;
  logic blocked;
  vrrl_digits_t digits;
  logic [2:0] pair_led;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  vrrl_core DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .remote_i(remote), .stage_i(stage), .voltage_i(volt), .ov_pct_i(ov_pct), .uv_pct_i(uv_pct),
    .volt_ab_i(10'h100), .volt_bc_i(10'h200), .volt_ca_i(10'h300), .block_i(block), .step_btn_i(step_btn),
    .reset_btn_i(reset_btn), .remote_reset_i(rr), .led_o(led), .start_route_o(route), .uv_blocked_o(blocked),
    .digits_o(digits), .pair_led_o(pair_led));
  vrrl_panel_model PANEL (.clock_i(clock_i), .press_i(press), .step_btn_o(step_btn), .reset_btn_o(reset_btn));
  ////////////////////////////////////////
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  // Whole run needs about 64000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic rem);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    remote <= rem;
    @(posedge clock_i);
    wr <= 1'b0;
    remote <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    `CHK(v, e)
    // Leave on an edge so the next stimulus lands on the clock
    @(posedge clock_i);
  endtask
  task automatic pulse(input vrrl_stage_t s);
    @(posedge clock_i);
    stage <= s;
    @(posedge clock_i);
    stage <= 4'h0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  // Keys pass a two-flop sync, so allow a dozen cycles
  task automatic press_keys(input logic [1:0] p);
    @(posedge clock_i);
    press <= p;
    @(posedge clock_i);
    press <= 2'b00;
    repeat (12) @(posedge clock_i);
    #1;
  endtask
  task automatic set_in(input vrrl_stage_t s, input logic [9:0] v, input int n);
    @(posedge clock_i);
    stage <= s;
    volt <= v;
    repeat (n) @(posedge clock_i);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic roll_ok;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      wr_reg(4'h2, ROWS[i].routing, 1'b0);
      @(posedge clock_i);
      stage <= ROWS[i].stg;
      block <= ROWS[i].blk;
      @(posedge clock_i);
      #1;
      `CHK(route, ROWS[i].route)
      `CHK(blocked, ROWS[i].blocked)
    end
    set_in(4'h0, 10'h3FF, 1);
    block <= 3'b000;
    pulse(4'b1100);
    `CHK(led, 4'b0010)
    press_keys(2'b01);
    `CHK(led, 4'b0010)
    press_keys(2'b10);
    `CHK(led, 4'b0000)
    wr_reg(4'h1, 8'hFE, 1'b0);
    pulse(4'b1100);
    press_keys(2'b01);
    `CHK(led, 4'b0010)
    wr_reg(4'h1, 8'h01, 1'b0);
    press_keys(2'b01);
    `CHK(led, 4'b0000)
    wr_reg(4'h0, 8'h05, 1'b0);
    pulse(4'b1111);
    `CHK(led, 4'b0101)
    @(posedge clock_i);
    rr <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    `CHK(led, 4'b0000)
    rchk(4'h7, 8'h10);
    rr <= 1'b0;
    wr_reg(4'h2, 8'h10, 1'b0);
    block <= 3'b001;
    rchk(4'h7, 8'h02);
    block <= 3'b000;
    // Start below the later peak so the overall maximum is observable
    volt <= 10'h100;
    wr_reg(4'h5, 8'h01, 1'b0);
    ov_pct <= 7'h32;
    uv_pct <= 7'h20;
    set_in(4'b1000, 10'h100, 3);
    set_in(4'b1000, 10'h200, 3);
    set_in(4'b1100, 10'h200, 3);
    set_in(4'b1100, 10'h300, 3);
    set_in(4'b0000, 10'h300, 3);
    rchk(4'h8, 8'h80);
    rchk(4'h9, 8'hC0);
    rchk(4'hE, 8'h64);
    rchk(4'hC, 8'h01);
    set_in(4'b0010, 10'h0C0, 3);
    set_in(4'b0010, 10'h080, 3);
    set_in(4'b0011, 10'h080, 3);
    set_in(4'b0011, 10'h040, 3);
    set_in(4'b0000, 10'h040, 3);
    rchk(4'hA, 8'h20);
    rchk(4'hB, 8'h10);
    rchk(4'hF, 8'h64);
    rchk(4'hD, 8'h01);
    ov_pct <= 7'h00;
    set_in(4'b1000, 10'h040, 3);
    rchk(4'hE, 8'h00);
    stage <= 4'h0;
    repeat (254) pulse(4'b1000);
    rchk(4'hC, 8'h00);
    set_in(4'b0000, 10'h000, 1);
    press_keys(2'b11);
    rchk(4'h9, 8'h00);
    rchk(4'hD, 8'h00);
    rchk(4'hF, 8'h00);
    set_in(4'b0000, 10'h3FF, 1);
    wr_reg(4'h5, 8'h01, 1'b0);
    rchk(4'hB, 8'hFF);
    wr_reg(4'h3, 8'h5A, 1'b0);
    wr_reg(4'h1, 8'h00, 1'b0);
    wr_reg(4'h1, 8'h01, 1'b1);
    rchk(4'h1, 8'h00);
    wr_reg(4'h4, 8'h33, 1'b1);
    wr_reg(4'h1, 8'h01, 1'b1);
    rchk(4'h1, 8'h00);
    wr_reg(4'h4, 8'h5A, 1'b1);
    wr_reg(4'h1, 8'h01, 1'b1);
    rchk(4'h1, 8'h01);
    wr_reg(4'h5, 8'h06, 1'b0);
    rchk(4'h3, 8'h00);
    rchk(4'h5, 8'h06);
    wr_reg(4'h1, 8'h00, 1'b1);
    rchk(4'h1, 8'h01);
    wr_reg(4'h5, 8'h00, 1'b0);
    repeat (62520) @(posedge clock_i);
    rd_reg(4'h3, v);
    roll_ok = (v == 8'h01) || (v == 8'h02);
    `CHK(roll_ok, 1'b1)
    wr_reg(4'h0, 8'h0F, 1'b0);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rchk(4'h0, 8'h0A);
    rchk(4'h1, 8'h00);
    rchk(4'h8, 8'h00);
    rchk(4'hA, 8'hFF);
    #1;
    `CHK(digits, 16'h0256)
    `CHK(pair_led, 3'b001)
    press_keys(2'b01);
    `CHK(digits, 16'h1000)
    repeat (2) press_keys(2'b01);
    `CHK(digits, 16'h3FFF)
    repeat (6) press_keys(2'b01);
    `CHK(digits, 16'h0512)
    `CHK(pair_led, 3'b010)
    stop_test();
  end
endmodule
